//--- core/pcm_alt_mux.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Port C pins 0-1: select clear is reserved; set gives analog or LED.
// - Port C pin 2: select clear is SPI slave select; set gives analog or LED.
// - Port C pins 3-5: clear gives SPI MISO, MOSI, SCK; set gives LED.
// - Port C pins 6-7: clear gives timer-two in/out; set gives LED.
// - Port D pins each carry one fixed peripheral function.
// - Second set register exists and reads back but never steers routing.
// - Selected function applies only while the pin's enable is set.
// - Ports D and E have no set registers.
// - On D and E the enable alone connects the single function.
// - Timer-four functions exist only in the larger package, else reserved.
// - Enable at subregister 02h, first set at 07h, second at 08h.
module pcm_alt_mux #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire pcm_pkg::pcm_wr_s  wr_in,
  output pcm_pkg::pcm_cfg_s      cfg_c_out,
  output logic [7:0]             cfg_d_en_out,
  output logic [7:0]             cfg_e_en_out,
  output pcm_pkg::pcm_route_e    route_c_out [8],
  output logic [7:0]             alt_d_out,
  output logic [7:0]             alt_e_out
);
  import pcm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Subregisters; ports A and B sit outside this block.

  pcm_cfg_s c_cfg;
  pcm_cfg_s d_cfg;
  pcm_cfg_s e_cfg;

  pcm_port_regs #(.HAS_SET(1'b1)) u_port_c (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .sel_in     (wr_in.port == PCM_PORT_C),
    .wr_in      (wr_in),
    .cfg_out    (c_cfg)
  );

  pcm_port_regs #(.HAS_SET(1'b0)) u_port_d (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .sel_in     (wr_in.port == PCM_PORT_D),
    .wr_in      (wr_in),
    .cfg_out    (d_cfg)
  );

  pcm_port_regs #(.HAS_SET(1'b0)) u_port_e (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .sel_in     (wr_in.port == PCM_PORT_E),
    .wr_in      (wr_in),
    .cfg_out    (e_cfg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Port C route decode; the high set register is deliberately not read.

  function automatic pcm_route_e route_c(input logic [2:0] pin, input logic en, input logic sel);
    pcm_route_e r;
    r = PCM_RT_GPIO;
    if (en) begin
      unique case (pin)
        3'h0, 3'h1: r = sel ? PCM_RT_ANALOG_LED : PCM_RT_RESERVED;
        3'h2:       r = sel ? PCM_RT_ANALOG_LED : PCM_RT_SPI_SS;
        3'h3:       r = sel ? PCM_RT_LED : PCM_RT_SPI_MISO;
        3'h4:       r = sel ? PCM_RT_LED : PCM_RT_SPI_MOSI;
        3'h5:       r = sel ? PCM_RT_LED : PCM_RT_SPI_SCK;
        3'h6:       r = sel ? PCM_RT_LED : PCM_RT_TIMER_TWO_IN;
        3'h7:       r = sel ? PCM_RT_LED : PCM_RT_TIMER_TWO_OUT;
      endcase
    end
    return r;
  endfunction

  pcm_route_e route_c_d [8];

  for (genvar i = 0; i < 8; i++) begin : g_c
    assign route_c_d[i] = route_c(3'(i), c_cfg.af_en[i], c_cfg.set_low[i]);
  end

  // Timer-four pins of Port E are reserved on the small package.
  wire [7:0] e_avail = LARGE_PACKAGE ? (PCM_E_TIMER_PINS | PCM_E_I2C_PINS) : PCM_E_I2C_PINS;

  wire [7:0] alt_d_d = d_cfg.af_en;
  wire [7:0] alt_e_d = e_cfg.af_en & e_avail;

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 8; i++) begin
        route_c_out[i] <= PCM_RT_GPIO;
      end
      alt_d_out    <= PCM_RST_BYTE;
      alt_e_out    <= PCM_RST_BYTE;
      cfg_c_out    <= '0;
      cfg_d_en_out <= PCM_RST_BYTE;
      cfg_e_en_out <= PCM_RST_BYTE;
    end else begin
      for (int i = 0; i < 8; i++) begin
        route_c_out[i] <= route_c_d[i];
      end
      alt_d_out    <= alt_d_d;
      alt_e_out    <= alt_e_d;
      cfg_c_out    <= c_cfg;
      cfg_d_en_out <= d_cfg.af_en;
      cfg_e_en_out <= e_cfg.af_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_c_disabled;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !c_cfg.af_en[3] |=> route_c_out[3] == PCM_RT_GPIO;
  endproperty
  a_c_disabled: assert property (p_c_disabled) else $error("Port C pin routed while disabled.");

  property p_c0_res;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    c_cfg.af_en[0] && !c_cfg.set_low[0] |=> route_c_out[0] == PCM_RT_RESERVED;
  endproperty
  a_c0_res: assert property (p_c0_res) else $error("Port C pin 0 not reserved.");

  property p_c2_ss;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    c_cfg.af_en[2] && !c_cfg.set_low[2] |=> route_c_out[2] == PCM_RT_SPI_SS;
  endproperty
  a_c2_ss: assert property (p_c2_ss) else $error("Port C pin 2 not slave select.");

  property p_c5_led;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    c_cfg.af_en[5] && c_cfg.set_low[5] |=> route_c_out[5] == PCM_RT_LED;
  endproperty
  a_c5_led: assert property (p_c5_led) else $error("Port C pin 5 not LED.");

  property p_c7_t2;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    c_cfg.af_en[7] && !c_cfg.set_low[7] |=> route_c_out[7] == PCM_RT_TIMER_TWO_OUT;
  endproperty
  a_c7_t2: assert property (p_c7_t2) else $error("Port C pin 7 not timer output.");

  property p_set_high_inert;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $stable(c_cfg.af_en) && $stable(c_cfg.set_low) ##1 $stable(c_cfg.af_en) && $stable(c_cfg.set_low)
      |-> $stable(route_c_out[6]);
  endproperty
  a_set_high_inert: assert property (p_set_high_inert) else $error("Route moved without cause.");

  property p_d_direct;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    1'b1 |=> alt_d_out == $past(d_cfg.af_en);
  endproperty
  a_d_direct: assert property (p_d_direct) else $error("Port D function not following enable.");

  property p_de_noset;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    {d_cfg.set_low, d_cfg.set_high, e_cfg.set_low, e_cfg.set_high} == 32'h00000000;
  endproperty
  a_de_noset: assert property (p_de_noset) else $error("Port D or E set register holds data.");

  property p_e_small;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !LARGE_PACKAGE |=> (alt_e_out & PCM_E_TIMER_PINS) == 8'h00;
  endproperty
  a_e_small: assert property (p_e_small) else $error("Timer-four pin active on small package.");

  property p_e_i2c;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    e_cfg.af_en[1] |=> alt_e_out[1];
  endproperty
  a_e_i2c: assert property (p_e_i2c) else $error("I2C clock pin not connected.");

  property p_af_write;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_in.wr && wr_in.port == PCM_PORT_D && wr_in.sub == PCM_SUB_AF |=> d_cfg.af_en == $past(wr_in.data);
  endproperty
  a_af_write: assert property (p_af_write) else $error("Enable subregister write lost.");

  property p_c1_res;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    c_cfg.af_en[1] && !c_cfg.set_low[1] |=> route_c_out[1] == PCM_RT_RESERVED;
  endproperty
  a_c1_res: assert property (p_c1_res) else $error("Port C pin 1 not reserved.");

  property p_c0_analog;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    c_cfg.af_en[0] && c_cfg.set_low[0] |=> route_c_out[0] == PCM_RT_ANALOG_LED;
  endproperty
  a_c0_analog: assert property (p_c0_analog) else $error("Port C pin 0 not analog or LED.");

  property p_c3_miso;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    c_cfg.af_en[3] && !c_cfg.set_low[3] |=> route_c_out[3] == PCM_RT_SPI_MISO;
  endproperty
  a_c3_miso: assert property (p_c3_miso) else $error("Port C pin 3 not SPI data in.");

  property p_c6_timer_two_input;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    c_cfg.af_en[6] && !c_cfg.set_low[6] |=> route_c_out[6] == PCM_RT_TIMER_TWO_IN;
  endproperty
  a_c6_timer_two_input: assert property (p_c6_timer_two_input) else $error("Port C pin 6 not timer input.");

  property p_c7_off;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !c_cfg.af_en[7] |=> route_c_out[7] == PCM_RT_GPIO;
  endproperty
  a_c7_off: assert property (p_c7_off) else $error("Port C pin 7 routed while disabled.");

  property p_e_large;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    LARGE_PACKAGE |=> alt_e_out == ($past(e_cfg.af_en) & (PCM_E_TIMER_PINS | PCM_E_I2C_PINS));
  endproperty
  a_e_large: assert property (p_e_large) else $error("Port E function not following enable.");

  property p_d_bad_sub;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_in.wr && wr_in.port == PCM_PORT_D && wr_in.sub != PCM_SUB_AF |=> $stable(d_cfg.af_en);
  endproperty
  a_d_bad_sub: assert property (p_d_bad_sub) else $error("Port D enable hit by other subregister.");

  property p_c_cfg_echo;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    1'b1 |=> cfg_c_out == $past(c_cfg);
  endproperty
  a_c_cfg_echo: assert property (p_c_cfg_echo) else $error("Port C read-back lost.");

endmodule

//--- core/pcm_pkg.sv
package pcm_pkg;

  // Port subregister codes written to the port address register.
  localparam logic [7:0] PCM_SUB_AF   = 8'h02;
  localparam logic [7:0] PCM_SUB_SET_LOW  = 8'h07;
  localparam logic [7:0] PCM_SUB_SET_HIGH = 8'h08;

  // Port E pins that carry the timer-four functions and the I2C functions.
  localparam logic [7:0] PCM_E_TIMER_PINS = 8'h79;
  localparam logic [7:0] PCM_E_I2C_PINS   = 8'h06;

  localparam logic [7:0] PCM_RST_BYTE = 8'h00;

  // Port identifiers for the control-port access.
  localparam logic [2:0] PCM_PORT_A = 3'h0;
  localparam logic [2:0] PCM_PORT_B = 3'h1;
  localparam logic [2:0] PCM_PORT_C = 3'h2;
  localparam logic [2:0] PCM_PORT_D = 3'h3;
  localparam logic [2:0] PCM_PORT_E = 3'h4;

  // Pin route codes presented to the pad logic.
  typedef enum logic [3:0] {
    PCM_RT_GPIO,
    PCM_RT_RESERVED,
    PCM_RT_ANALOG_LED,
    PCM_RT_LED,
    PCM_RT_SPI_SS,
    PCM_RT_SPI_MISO,
    PCM_RT_SPI_MOSI,
    PCM_RT_SPI_SCK,
    PCM_RT_TIMER_TWO_IN,
    PCM_RT_TIMER_TWO_OUT,
    PCM_RT_SINGLE
  } pcm_route_e;

  // Control-port write request.
  typedef struct packed {
    logic       wr;
    logic [2:0] port;
    logic [7:0] sub;
    logic [7:0] data;
  } pcm_wr_s;

  // Per-port configuration read-back.
  typedef struct packed {
    logic [7:0] af_en;
    logic [7:0] set_low;
    logic [7:0] set_high;
  } pcm_cfg_s;

endpackage

//--- core/pcm_port_regs.sv
`timescale 1ns/1ps
// One port's enable and set subregisters.
module pcm_port_regs #(
  parameter bit HAS_SET = 1'b1
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             sel_in,
  input  wire pcm_pkg::pcm_wr_s wr_in,
  output pcm_pkg::pcm_cfg_s     cfg_out
);
  import pcm_pkg::*;

  wire wr_af   = sel_in && wr_in.wr && (wr_in.sub == PCM_SUB_AF);
  wire wr_set1 = sel_in && wr_in.wr && (wr_in.sub == PCM_SUB_SET_LOW) && HAS_SET;
  wire wr_set2 = sel_in && wr_in.wr && (wr_in.sub == PCM_SUB_SET_HIGH) && HAS_SET;

  logic [7:0] af_q;
  logic [7:0] s1_q;
  logic [7:0] s2_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      af_q <= PCM_RST_BYTE;
      s1_q <= PCM_RST_BYTE;
      s2_q <= PCM_RST_BYTE;
    end else begin
      if (wr_af) begin
        af_q <= wr_in.data;
      end
      if (wr_set1) begin
        s1_q <= wr_in.data;
      end
      if (wr_set2) begin
        s2_q <= wr_in.data;
      end
    end
  end

  // Ports without set registers read them as zero.
  assign cfg_out = '{af_en: af_q, set_low: s1_q, set_high: s2_q};

endmodule

//--- test/pcm_pin_model.sv
`timescale 1ns/1ps
// Board-side view of Port C: flags each pin whose route leaves it to the LED driver.
module pcm_pin_model (
  input  wire pcm_pkg::pcm_route_e route_c_in [8],
  output logic [7:0]               led_c_out
);
  import pcm_pkg::*;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      led_c_out[i] = (route_c_in[i] == PCM_RT_ANALOG_LED) || (route_c_in[i] == PCM_RT_LED);
    end
  end
endmodule

//--- test/port_c_to_e_alt_function_mux_tb_top.sv
`timescale 1ns/1ps
module port_c_to_e_alt_function_mux_tb_top;
  import pcm_pkg::*;
  logic       clk_sys_in = 1'b0;
  logic       rst_n_in   = 1'b0;
  pcm_wr_s    wr_in      = '0;
  pcm_cfg_s   cfg_c_out;
  logic [7:0] cfg_d_en_out, cfg_e_en_out, alt_d_out, alt_e_out, led_c, alt_e_small;
  pcm_route_e route_c_out [8];
  int         bad_count   = 0;
  int         comparisons = 0;
  localparam pcm_route_e RT_CLR [8] = '{PCM_RT_RESERVED, PCM_RT_RESERVED, PCM_RT_SPI_SS, PCM_RT_SPI_MISO,
    PCM_RT_SPI_MOSI, PCM_RT_SPI_SCK, PCM_RT_TIMER_TWO_IN, PCM_RT_TIMER_TWO_OUT};
  localparam pcm_route_e RT_SET [8] = '{PCM_RT_ANALOG_LED, PCM_RT_ANALOG_LED, PCM_RT_ANALOG_LED, PCM_RT_LED,
    PCM_RT_LED, PCM_RT_LED, PCM_RT_LED, PCM_RT_LED};

  initial forever #50 clk_sys_in = ~clk_sys_in;

  pcm_alt_mux #(.LARGE_PACKAGE(1'b1)) u_dut (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .wr_in       (wr_in),
    .cfg_c_out   (cfg_c_out),
    .cfg_d_en_out(cfg_d_en_out),
    .cfg_e_en_out(cfg_e_en_out),
    .route_c_out (route_c_out),
    .alt_d_out   (alt_d_out),
    .alt_e_out   (alt_e_out)
  );

  pcm_pin_model u_pins (
    .route_c_in(route_c_out),
    .led_c_out (led_c)
  );

  // The small package only differs on Port E, so only that output is watched.
  pcm_alt_mux #(.LARGE_PACKAGE(1'b0)) u_dut_small (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .wr_in       (wr_in),
    .cfg_c_out   (),
    .cfg_d_en_out(),
    .cfg_e_en_out(),
    .route_c_out (),
    .alt_d_out   (),
    .alt_e_out   (alt_e_small)
  );

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rt(input pcm_route_e got, input pcm_route_e exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The strobe drops just after the edge that takes it, and the next call waits one more edge.
  task automatic wr(input logic [2:0] p, input logic [7:0] s, input logic [7:0] d);
    @(posedge clk_sys_in);
    #1;
    wr_in = '{1'b1, p, s, d};
    @(posedge clk_sys_in);
    #1;
    wr_in.wr = 1'b0;
  endtask

  task automatic settle;
    @(posedge clk_sys_in);
    #1;
  endtask

  task automatic t_reset;
    chk8(alt_d_out | alt_e_out | alt_e_small | cfg_d_en_out | cfg_e_en_out, 8'h00);
    chk8(cfg_c_out.af_en | cfg_c_out.set_low | cfg_c_out.set_high, 8'h00);
    for (int i = 0; i < 8; i++) chk_rt(route_c_out[i], PCM_RT_GPIO);
    $display("test reset done");
  endtask

  task automatic t_port_c;
    wr(PCM_PORT_C, PCM_SUB_AF, 8'hFF);
    wr(PCM_PORT_C, PCM_SUB_SET_LOW, 8'h00);
    settle();
    for (int i = 0; i < 8; i++) chk_rt(route_c_out[i], RT_CLR[i]);
    chk8(led_c, 8'h00);
    wr(PCM_PORT_C, PCM_SUB_SET_LOW, 8'hFF);
    settle();
    for (int i = 0; i < 8; i++) chk_rt(route_c_out[i], RT_SET[i]);
    chk8(led_c, 8'hFF);
    wr(PCM_PORT_C, PCM_SUB_SET_HIGH, 8'hAA);
    wr(PCM_PORT_C, 8'h03, 8'h55);
    settle();
    chk8(cfg_c_out.set_high, 8'hAA);
    chk8(cfg_c_out.set_low, 8'hFF);
    for (int i = 0; i < 8; i++) chk_rt(route_c_out[i], RT_SET[i]);
    wr(PCM_PORT_C, PCM_SUB_AF, 8'h0F);
    settle();
    for (int i = 0; i < 8; i++) chk_rt(route_c_out[i], (i < 4) ? RT_SET[i] : PCM_RT_GPIO);
    chk8(cfg_c_out.af_en, 8'h0F);
    chk8(led_c, 8'h0F);
    $display("test port c done");
  endtask

  task automatic t_port_de;
    wr(PCM_PORT_D, PCM_SUB_AF, 8'hA5);
    wr(PCM_PORT_E, PCM_SUB_AF, 8'hFF);
    wr(PCM_PORT_D, PCM_SUB_SET_LOW, 8'hFF);
    wr(PCM_PORT_E, PCM_SUB_SET_HIGH, 8'hFF);
    settle();
    chk8(alt_d_out, 8'hA5);
    chk8(alt_e_out, 8'h7F);
    chk8(alt_e_small, 8'h06);
    chk8(cfg_d_en_out, 8'hA5);
    chk8(cfg_e_en_out, 8'hFF);
    wr(PCM_PORT_A, PCM_SUB_AF, 8'h00);
    wr(PCM_PORT_B, PCM_SUB_AF, 8'h00);
    settle();
    chk8(cfg_d_en_out, 8'hA5);
    chk8(cfg_e_en_out, 8'hFF);
    chk8(cfg_c_out.af_en, 8'h0F);
    $display("test port d e done");
  endtask

  // A reset in mid-run must clear every subregister and route, and writes must work again after it.
  task automatic t_mid_reset;
    @(posedge clk_sys_in);
    #1;
    rst_n_in = 1'b0;
    #1;
    t_reset();
    settle();
    rst_n_in = 1'b1;
    settle();
    t_reset();
    wr(PCM_PORT_D, PCM_SUB_AF, 8'h3C);
    settle();
    chk8(alt_d_out, 8'h3C);
    $display("test mid reset done");
  endtask

  task automatic finish_test;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_sys_in);
    #1;
    t_reset();
    rst_n_in = 1'b1;
    t_port_c();
    t_port_de();
    t_mid_reset();
    finish_test();
  end
endmodule
